// *** rtl/dual_timer_counter.sv ***
// Purpose: Two timer/counters with shared control, mode and external interrupt flags.
// Assumes: Register port with one-cycle strobes; pins asynchronous to clk_sys.
// Notes:   Software writes to a count byte win over counting in the same cycle.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"

// Functional notes
// - Each timer overflow sets its flag (timer 1's only while timer 0 is not in mode 11), and the vector acknowledge clears it.
// - A timer counts only while its run bit is one and holds otherwise; in mode 11 the timer 0 high byte follows timer 1's run bit instead.
// - A falling edge on an interrupt pin sets its edge flag; the vector acknowledge clears it only with falling-edge triggering selected.
// - Trigger type zero selects low-level triggering and one selects falling-edge triggering.
// - With gating set, a timer runs only while its interrupt pin is high and its run bit is set.
// - In timer mode a timer advances once every two system clock cycles.
// - In counter mode a timer advances once per falling edge of its count pin.
// - Mode 00 is an 8-bit high byte fed by a 5-bit prescaler; mode 01 is one 16-bit count.
// - Mode 10 makes the low byte an 8-bit counter reloaded from the high byte on overflow.
// - Timer 1 in mode 11 stops counting.
// - Timer 0 in mode 11 splits into two 8-bit counters, the high one run by timer 1's run bit and setting timer 1's flag.
// - A timer requests an interrupt only while its enable and the global enable are set.
module dual_timer_counter #(
  parameter int TIMER_DIV = `TIMER_DIV_DEFAULT
) (
  input  wire logic       clk_sys,        // System clock, 125 MHz.
  input  wire logic       rst,            // Asynchronous reset, active high.
  input  wire logic [7:0] reg_addr,       // Register address.
  input  wire logic [7:0] reg_wdata,      // Write data.
  input  wire logic       reg_wr,         // Write strobe.
  input  wire logic       reg_rd,         // Read strobe.
  output logic      [7:0] reg_rdata,      // Read data, the cycle after the strobe.
  input  wire logic       count_pin_a,    // Timer 0 count pin.
  input  wire logic       count_pin_b,    // Timer 1 count pin.
  input  wire logic       ext_irq_pin_a,  // External interrupt 0 and timer 0 gate pin.
  input  wire logic       ext_irq_pin_b,  // External interrupt 1 and timer 1 gate pin.
  input  wire logic       vec_ack_t0,     // Processor vectored to timer 0 service.
  input  wire logic       vec_ack_t1,     // Processor vectored to timer 1 service.
  input  wire logic       vec_ack_ext0,   // Processor vectored to external 0 service.
  input  wire logic       vec_ack_ext1,   // Processor vectored to external 1 service.
  output logic            t0_irq_req,     // Timer 0 interrupt request.
  output logic            t1_irq_req,     // Timer 1 interrupt request.
  output logic            ext0_irq_req,   // External 0 interrupt request.
  output logic            ext1_irq_req,   // External 1 interrupt request.
  output logic            irq             // Masked event status interrupt.
);
  import timer_pkg::*;

  localparam int DIV_W = (TIMER_DIV > 1) ? $clog2(TIMER_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TIMER_DIV - 1);

  logic [7:0]       ctrl_q, ctrl_d;
  logic [7:0]       timer_mode_q;
  logic [7:0]       t0_lo_q, t0_lo_d, t0_hi_q, t0_hi_d;
  logic [7:0]       t1_lo_q, t1_lo_d, t1_hi_q, t1_hi_d;
  logic [`EVT_MSB:0] stat_q, mask_q, events;
  logic [7:0]       ien_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0]       rdata_q;
  logic             cnt0_lvl, cnt0_fall, cnt1_lvl, cnt1_fall;
  logic             ext_irq_pin_a_lvl, ext_irq_pin_a_fall, ext_irq_pin_b_lvl, ext_irq_pin_b_fall;
  logic             tick, t0_en, t1_en, t0_inc, t1_inc, th0_inc;
  logic             ovf0, ovf1, ovf_th0;
  logic [16:0]      step0, step1;
  timer_mode_t      t0_mode, t1_mode;
  logic             wr_ctrl, wr_t0l, wr_t0h, wr_t1l, wr_t1h;

  // Synchronisers for the four pins.
  pin_sync_fall u_cnt0 (.clk_sys(clk_sys), .rst(rst), .pin(count_pin_a),
                        .level(cnt0_lvl), .fall(cnt0_fall));
  pin_sync_fall u_cnt1 (.clk_sys(clk_sys), .rst(rst), .pin(count_pin_b),
                        .level(cnt1_lvl), .fall(cnt1_fall));
  pin_sync_fall u_ext_irq_pin_a (.clk_sys(clk_sys), .rst(rst), .pin(ext_irq_pin_a),
                        .level(ext_irq_pin_a_lvl), .fall(ext_irq_pin_a_fall));
  pin_sync_fall u_ext_irq_pin_b (.clk_sys(clk_sys), .rst(rst), .pin(ext_irq_pin_b),
                        .level(ext_irq_pin_b_lvl), .fall(ext_irq_pin_b_fall));

  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_TIMER_CONTROL);
  assign wr_t0l  = reg_wr && (reg_addr == `ADDR_T0_COUNT_LOW);
  assign wr_t0h  = reg_wr && (reg_addr == `ADDR_T0_COUNT_HIGH);
  assign wr_t1l  = reg_wr && (reg_addr == `ADDR_T1_COUNT_LOW);
  assign wr_t1h  = reg_wr && (reg_addr == `ADDR_T1_COUNT_HIGH);

  // One count step in modes 00, 01 and 10; mode 11 steps only the low byte.
  function automatic logic [16:0] count_step(input timer_mode_t mode,
                                             input logic [7:0]  hi,
                                             input logic [7:0]  lo);
    logic [5:0]  pre;
    logic [8:0]  hsum;
    logic [8:0]  lsum;
    logic [16:0] wsum;
    begin
      pre  = {1'b0, lo[`PRE_MSB:0]} + 6'h01;
      hsum = {1'b0, hi} + 9'h001;
      lsum = {1'b0, lo} + 9'h001;
      wsum = {1'b0, hi, lo} + 17'h00001;
      unique case (mode)
        MODE_PRESCALED:
          count_step = pre[5] ? {hsum, lo[7:`PRE_MSB+1], pre[`PRE_MSB:0]}
                              : {1'b0, hi, lo[7:`PRE_MSB+1], pre[`PRE_MSB:0]};
        MODE_16BIT:
          count_step = wsum;
        MODE_RELOAD:
          count_step = lsum[8] ? {1'b1, hi, hi} : {1'b0, hi, lsum[7:0]};
        MODE_SPLIT:
          count_step = {lsum[8], hi, lsum[7:0]};
      endcase
    end
  endfunction

  // Divider for the timer-mode rate.
  assign tick = (div_q == DIV_LAST);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + DIV_W'(1);
  end

  assign t0_mode = timer_mode_t'(timer_mode_q[`MOD_T0_HI:`MOD_T0_LO]);
  assign t1_mode = timer_mode_t'(timer_mode_q[`MOD_T1_HI:`MOD_T1_LO]);
  assign t0_en   = ctrl_q[`CTL_T0_RUN] && (!timer_mode_q[`MOD_T0_GATE] || ext_irq_pin_a_lvl);
  assign t1_en   = ctrl_q[`CTL_T1_RUN] && (!timer_mode_q[`MOD_T1_GATE] || ext_irq_pin_b_lvl);
  assign t0_inc  = t0_en && (timer_mode_q[`MOD_T0_CNT] ? cnt0_fall : tick);
  assign t1_inc  = t1_en && (t1_mode != MODE_SPLIT)
                   && (timer_mode_q[`MOD_T1_CNT] ? cnt1_fall : tick);
  assign th0_inc = (t0_mode == MODE_SPLIT) && ctrl_q[`CTL_T1_RUN] && tick;
  assign step0   = count_step(t0_mode, t0_hi_q, t0_lo_q);
  assign step1   = count_step(t1_mode, t1_hi_q, t1_lo_q);
  assign ovf_th0 = th0_inc && (t0_hi_q == `BYTE_ONES);
  assign ovf0    = t0_inc && step0[16];
  // While timer 0 is split, timer 1's flag belongs to the timer 0 high byte.
  assign ovf1    = (t0_mode == MODE_SPLIT) ? ovf_th0 : (t1_inc && step1[16]);

  always_comb
  begin
    t0_lo_d = t0_lo_q;
    t0_hi_d = t0_hi_q;
    t1_lo_d = t1_lo_q;
    t1_hi_d = t1_hi_q;
    if (t0_inc)
    begin
      t0_hi_d = step0[15:8];
      t0_lo_d = step0[7:0];
    end
    if (th0_inc)
      t0_hi_d = t0_hi_q + 8'h01;
    if (t1_inc)
    begin
      t1_hi_d = step1[15:8];
      t1_lo_d = step1[7:0];
    end
    if (wr_t0l)
      t0_lo_d = reg_wdata;
    if (wr_t0h)
      t0_hi_d = reg_wdata;
    if (wr_t1l)
      t1_lo_d = reg_wdata;
    if (wr_t1h)
      t1_hi_d = reg_wdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      t0_lo_q <= `RST_BYTE;
      t0_hi_q <= `RST_BYTE;
      t1_lo_q <= `RST_BYTE;
      t1_hi_q <= `RST_BYTE;
    end
    else
    begin
      t0_lo_q <= t0_lo_d;
      t0_hi_q <= t0_hi_d;
      t1_lo_q <= t1_lo_d;
      t1_hi_q <= t1_hi_d;
    end
  end

  // Control flags: software write, then vector clear, then hardware set.
  always_comb
  begin
    ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;
    if (vec_ack_t0)
      ctrl_d[`CTL_T0_OVF] = 1'b0;
    if (vec_ack_t1)
      ctrl_d[`CTL_T1_OVF] = 1'b0;
    if (vec_ack_ext0 && ctrl_q[`CTL_EXT0_TRG])
      ctrl_d[`CTL_EXT0_EDG] = 1'b0;
    if (vec_ack_ext1 && ctrl_q[`CTL_EXT1_TRG])
      ctrl_d[`CTL_EXT1_EDG] = 1'b0;
    if (ovf0)
      ctrl_d[`CTL_T0_OVF] = 1'b1;
    if (ovf1)
      ctrl_d[`CTL_T1_OVF] = 1'b1;
    if (!ctrl_q[`CTL_EXT0_TRG])
      ctrl_d[`CTL_EXT0_EDG] = !ext_irq_pin_a_lvl;
    else if (ext_irq_pin_a_fall)
      ctrl_d[`CTL_EXT0_EDG] = 1'b1;
    if (!ctrl_q[`CTL_EXT1_TRG])
      ctrl_d[`CTL_EXT1_EDG] = !ext_irq_pin_b_lvl;
    else if (ext_irq_pin_b_fall)
      ctrl_d[`CTL_EXT1_EDG] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_q <= `RST_BYTE;
    else
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_mode_q <= `RST_BYTE;
      mask_q <= `RST_EVT;
      ien_q  <= `RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_TIMER_MODE)
        timer_mode_q <= reg_wdata;
      if (reg_addr == `ADDR_EVENT_MASK)
        mask_q <= reg_wdata[`EVT_MSB:0];
      if (reg_addr == `ADDR_IRQ_ENABLE)
        ien_q <= reg_wdata;
    end
  end

  // Sticky event status, write one to clear; a new event wins over the clear.
  assign events = {ext_irq_pin_b_fall, ext_irq_pin_a_fall, ovf1, ovf0};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stat_q <= `RST_EVT;
    else if (reg_wr && (reg_addr == `ADDR_EVENT_STATUS))
      stat_q <= (stat_q & ~reg_wdata[`EVT_MSB:0]) | events;
    else
      stat_q <= stat_q | events;
  end

  assign irq          = |(stat_q & mask_q);
  assign t0_irq_req   = ctrl_q[`CTL_T0_OVF] && ien_q[`IEN_T0] && ien_q[`IEN_GLOBAL];
  assign t1_irq_req   = ctrl_q[`CTL_T1_OVF] && ien_q[`IEN_T1] && ien_q[`IEN_GLOBAL];
  assign ext0_irq_req = ctrl_q[`CTL_EXT0_EDG] && ien_q[`IEN_EXT0] && ien_q[`IEN_GLOBAL];
  assign ext1_irq_req = ctrl_q[`CTL_EXT1_EDG] && ien_q[`IEN_EXT1] && ien_q[`IEN_GLOBAL];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= `RST_BYTE;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ADDR_TIMER_CONTROL: rdata_q <= ctrl_q;
        `ADDR_TIMER_MODE:    rdata_q <= timer_mode_q;
        `ADDR_T0_COUNT_LOW:  rdata_q <= t0_lo_q;
        `ADDR_T1_COUNT_LOW:  rdata_q <= t1_lo_q;
        `ADDR_T0_COUNT_HIGH: rdata_q <= t0_hi_q;
        `ADDR_T1_COUNT_HIGH: rdata_q <= t1_hi_q;
        `ADDR_EVENT_STATUS:  rdata_q <= {4'h0, stat_q};
        `ADDR_EVENT_MASK:    rdata_q <= {4'h0, mask_q};
        `ADDR_IRQ_ENABLE:    rdata_q <= ien_q;
        default:             rdata_q <= `RST_BYTE;
      endcase
    end
    else
      rdata_q <= `RST_BYTE;
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ovf_sets_flag: assert property (ovf0 |=> ctrl_q[`CTL_T0_OVF])
    else $error("timer 0 overflow did not set its flag");
  a_ack_clears_flag: assert property (vec_ack_t1 && !ovf1 && !wr_ctrl |=> !ctrl_q[`CTL_T1_OVF])
    else $error("vector acknowledge did not clear timer 1 flag");
  a_run_off_hold: assert property (!ctrl_q[`CTL_T0_RUN] && !wr_t0l && !wr_t0h && t0_mode != MODE_SPLIT
                                   |=> $stable(t0_lo_q) && $stable(t0_hi_q))
    else $error("timer 0 counted while stopped");
  a_edge_flag_set: assert property (ctrl_q[`CTL_EXT0_TRG] && ext_irq_pin_a_fall |=> ctrl_q[`CTL_EXT0_EDG])
    else $error("falling edge did not set edge flag");
  a_level_follows: assert property (!ctrl_q[`CTL_EXT1_TRG] && !wr_ctrl
                                    |=> ctrl_q[`CTL_EXT1_EDG] == !$past(ext_irq_pin_b_lvl))
    else $error("level trigger flag does not follow pin");
  a_gate_blocks: assert property (timer_mode_q[`MOD_T1_GATE] && !ext_irq_pin_b_lvl && !wr_t1l && !wr_t1h
                                  |=> $stable({t1_hi_q, t1_lo_q}))
    else $error("gated timer 1 counted with pin low");
  a_timer_rate: assert property ((t1_mode == MODE_16BIT && !timer_mode_q[`MOD_T1_CNT] && t1_en
                                  && !wr_t1l && !wr_t1h && !wr_ctrl) [*2]
                                 |=> {t1_hi_q, t1_lo_q} == $past({t1_hi_q, t1_lo_q}, 2) + 16'h0001)
    else $error("timer mode rate is not one step per two cycles");
  a_counter_edge: assert property (t0_mode == MODE_16BIT && timer_mode_q[`MOD_T0_CNT] && t0_en
                                   && !wr_t0l && !wr_t0h
                                   |=> {t0_hi_q, t0_lo_q} == $past({t0_hi_q, t0_lo_q})
                                       + {15'h0000, $past(cnt0_fall)})
    else $error("counter mode step does not match pin edges");
  a_prescale_carry: assert property (t0_mode == MODE_PRESCALED && t0_inc
                                     && t0_lo_q[`PRE_MSB:0] == `PRE_ONES && !wr_t0l && !wr_t0h
                                     |=> t0_hi_q == $past(t0_hi_q) + 8'h01)
    else $error("prescaler carry did not advance high byte");
  a_reload_value: assert property (t1_mode == MODE_RELOAD && t1_inc && t1_lo_q == `BYTE_ONES
                                   && !wr_t1l && !wr_t1h && t0_mode != MODE_SPLIT
                                   |=> t1_lo_q == $past(t1_hi_q) && ctrl_q[`CTL_T1_OVF])
    else $error("reload mode did not reload or flag");
  a_t1_stopped: assert property (t1_mode == MODE_SPLIT && !wr_t1l && !wr_t1h
                                 |=> $stable({t1_hi_q, t1_lo_q}))
    else $error("timer 1 counted in mode 11");
  a_split_high: assert property (th0_inc && t0_hi_q == `BYTE_ONES && !wr_t0h
                                 |=> ctrl_q[`CTL_T1_OVF] && t0_hi_q == `RST_BYTE)
    else $error("split high byte overflow did not set timer 1 flag");
  a_split_low: assert property (t0_mode == MODE_SPLIT && t0_inc && t0_lo_q == `BYTE_ONES
                                |=> ctrl_q[`CTL_T0_OVF])
    else $error("split low byte overflow did not set timer 0 flag");
  a_global_gate: assert property (!ien_q[`IEN_GLOBAL] |-> !t0_irq_req && !t1_irq_req)
    else $error("timer request without global enable");

  c_reload_ovf: cover property (t1_mode == MODE_RELOAD && ovf1);
  c_split_high: cover property (ovf_th0);
  c_edge_event: cover property (ctrl_q[`CTL_EXT0_TRG] && ext_irq_pin_a_fall ##1 vec_ack_ext0);
  c_irq_line:   cover property ($rose(irq));
endmodule
`default_nettype wire

// *** rtl/timer_consts.svh ***
// Purpose: Register offsets, field positions and reset values of the dual timer block.
// Assumes: Included by bare name from every file that needs a constant.
// Notes:   Definitions only.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define ADDR_TIMER_CONTROL  8'h88
`define ADDR_TIMER_MODE     8'h89
`define ADDR_T0_COUNT_LOW   8'h8A
`define ADDR_T1_COUNT_LOW   8'h8B
`define ADDR_T0_COUNT_HIGH  8'h8C
`define ADDR_T1_COUNT_HIGH  8'h8D
`define ADDR_EVENT_STATUS   8'hC0
`define ADDR_EVENT_MASK     8'hC1
`define ADDR_IRQ_ENABLE     8'hC2

`define CTL_T1_OVF   7
`define CTL_T1_RUN   6
`define CTL_T0_OVF   5
`define CTL_T0_RUN   4
`define CTL_EXT1_EDG 3
`define CTL_EXT1_TRG 2
`define CTL_EXT0_EDG 1
`define CTL_EXT0_TRG 0

`define MOD_T1_GATE  7
`define MOD_T1_CNT   6
`define MOD_T1_HI    5
`define MOD_T1_LO    4
`define MOD_T0_GATE  3
`define MOD_T0_CNT   2
`define MOD_T0_HI    1
`define MOD_T0_LO    0

`define EVT_T0_OVF   0
`define EVT_T1_OVF   1
`define EVT_EXT0     2
`define EVT_EXT1     3
`define EVT_MSB      3

`define IEN_T0       0
`define IEN_T1       1
`define IEN_EXT0     2
`define IEN_EXT1     3
`define IEN_GLOBAL   7

`define PRE_MSB      4
`define RST_BYTE     8'h00
`define RST_EVT      4'h0
`define BYTE_ONES    8'hFF
`define PRE_ONES     5'h1F
`define TIMER_DIV_DEFAULT 2

`endif

// *** rtl/timer_pkg.sv ***
// Purpose: Shared types of the dual timer block.
// Assumes: Nothing.
// Notes:   Mode order follows the two-bit mode field encoding.
package timer_pkg;
  typedef enum logic [1:0] {MODE_PRESCALED, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} timer_mode_t;
endpackage

// *** rtl/pin_sync_fall.sv ***
// Purpose: Two-stage synchroniser for one pin, with a falling-edge pulse.
// Assumes: Pin is asynchronous to clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pin_sync_fall #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input  wire logic clk_sys,   // System clock.
  input  wire logic rst,       // Asynchronous reset, active high.
  input  wire logic pin,       // Raw pin level.
  output logic      level,     // Synchronised level.
  output logic      fall       // One-cycle pulse per falling edge.
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;
endmodule
`default_nettype wire

// *** sim/pin_partner.sv ***
// Purpose: Drives the count pins and external interrupt pins of the dual timer.
// Assumes: Pins idle high, as with a pull-up, and change just after a clock edge.
// Notes:   Each pulse level is held two to four clocks, chosen at random.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic clk_sys,        // System clock.
  output logic      count_pin_a,    // Timer 0 count pin.
  output logic      count_pin_b,    // Timer 1 count pin.
  output logic      ext_irq_pin_a,  // External interrupt 0 pin.
  output logic      ext_irq_pin_b   // External interrupt 1 pin.
);
  logic [1:0] cnt_q;
  logic [1:0] ext_q;
  assign count_pin_a   = cnt_q[0];
  assign count_pin_b   = cnt_q[1];
  assign ext_irq_pin_a = ext_q[0];
  assign ext_irq_pin_b = ext_q[1];
  initial
  begin
    cnt_q = 2'h3;
    ext_q = 2'h3;
  end
  task automatic pulse_count(input int sel, input int n);
    repeat (n)
    begin
      cnt_q[sel] <= 1'b0;
      repeat ($urandom_range(4, 2)) @(posedge clk_sys);
      cnt_q[sel] <= 1'b1;
      repeat ($urandom_range(4, 2)) @(posedge clk_sys);
    end
  endtask
  task automatic set_ext(input int sel, input logic lvl);
    ext_q[sel] <= lvl;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// *** sim/test_dual_timer_counter_ext_irq.sv ***
// Purpose: Self-checking bench for the dual timer/counter block.
// Assumes: Register port with one-cycle strobes, read data the cycle after.
// Notes:   Run windows span an even number of edges, so timer steps are exact.
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.svh"
module test_dual_timer_counter_ext_irq;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [3:0]  vec_ack;
  logic        t0_irq_req;
  logic        t1_irq_req;
  logic        ext0_irq_req;
  logic        ext1_irq_req;
  logic        irq;
  wire logic   cpa;
  wire logic   cpb;
  wire logic   epa;
  wire logic   epb;
  logic [15:0] w;
  logic [15:0] e;
  int          fails;
  int          n_tests;
  int          n;
  dual_timer_counter #(.TIMER_DIV(2)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .count_pin_a(cpa), .count_pin_b(cpb), .ext_irq_pin_a(epa),
    .ext_irq_pin_b(epb), .vec_ack_t0(vec_ack[0]), .vec_ack_t1(vec_ack[1]),
    .vec_ack_ext0(vec_ack[2]), .vec_ack_ext1(vec_ack[3]), .t0_irq_req(t0_irq_req),
    .t1_irq_req(t1_irq_req), .ext0_irq_req(ext0_irq_req), .ext1_irq_req(ext1_irq_req),
    .irq(irq));
  pin_partner pp_u (.clk_sys(clk_sys), .count_pin_a(cpa), .count_pin_b(cpb),
    .ext_irq_pin_a(epa), .ext_irq_pin_b(epb));
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;
  // Next value of a prescaled count: five-bit prescaler carries into the high byte.
  function automatic logic [15:0] exp_pre(input logic [15:0] v);
    return {v[15:8] + {7'h00, v[4:0] == 5'h1F}, v[7:5], v[4:0] + 5'h01};
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
    chk_byte(d, exp);
  endtask
  task automatic ack(input int i);
    vec_ack[i] <= 1'b1;
    @(posedge clk_sys);
    vec_ack[i] <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic set_t0(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi);
    wr(`ADDR_TIMER_MODE, md);
    wr(`ADDR_T0_COUNT_LOW, lo);
    wr(`ADDR_T0_COUNT_HIGH, hi);
  endtask
  // Runs for exactly 2*k edges, which is k timer-mode steps.
  task automatic run_steps(input logic [7:0] c, input int k);
    wr(`ADDR_TIMER_CONTROL, c);
    repeat (2 * k - 2) @(posedge clk_sys);
    wr(`ADDR_TIMER_CONTROL, 8'h00);
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #(8 * 40000);
    fails++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    vec_ack = 4'h0;
    fails = 0;
    n_tests = 0;
    n = $urandom(36);
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 'h88; a <= 'h8D; a++)
      rdchk(8'(a), 8'h00);
    wr(8'h90, 8'h55);
    rdchk(8'h90, 8'h00);
    set_t0(8'h01, 8'h00, 8'h00);
    run_steps(8'h10, 20);
    rdchk(`ADDR_T0_COUNT_LOW, 8'h14);
    repeat (10) @(posedge clk_sys);
    rdchk(`ADDR_T0_COUNT_LOW, 8'h14);
    set_t0(8'h01, 8'hFF, 8'h7F);
    run_steps(8'h10, 1);
    rdchk(`ADDR_T0_COUNT_HIGH, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      w = 16'($urandom);
      set_t0(8'h00, w[7:0], w[15:8]);
      run_steps(8'h10, 1);
      e = exp_pre(w);
      rdchk(`ADDR_T0_COUNT_LOW, e[7:0]);
      rdchk(`ADDR_T0_COUNT_HIGH, e[15:8]);
      set_t0(8'h02, 8'hFF, w[15:8]);
      run_steps(8'h10, 1);
      rdchk(`ADDR_T0_COUNT_LOW, w[15:8]);
    end
    wr(`ADDR_EVENT_STATUS, 8'h0F);
    set_t0(8'h03, 8'hFF, 8'hFF);
    run_steps(8'h40, 1);
    rdchk(`ADDR_T0_COUNT_HIGH, 8'h00);
    rdchk(`ADDR_T0_COUNT_LOW, 8'hFF);
    rdchk(`ADDR_EVENT_STATUS, 8'h02);
    run_steps(8'h10, 1);
    rdchk(`ADDR_T0_COUNT_LOW, 8'h00);
    rdchk(`ADDR_EVENT_STATUS, 8'h03);
    wr(`ADDR_TIMER_MODE, 8'h30);
    wr(`ADDR_T1_COUNT_LOW, 8'h05);
    run_steps(8'h40, 5);
    rdchk(`ADDR_T1_COUNT_LOW, 8'h05);
    wr(`ADDR_TIMER_MODE, 8'h10);
    run_steps(8'h40, 3);
    rdchk(`ADDR_T1_COUNT_LOW, 8'h08);
    wr(`ADDR_EVENT_STATUS, 8'h0F);
    wr(`ADDR_EVENT_MASK, 8'h01);
    wr(`ADDR_IRQ_ENABLE, 8'h01);
    set_t0(8'h01, 8'hFE, 8'hFF);
    wr(`ADDR_TIMER_CONTROL, 8'h10);
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    chk_bit(irq, 1'b1);
    chk_bit(t0_irq_req, 1'b0);
    rdchk(`ADDR_TIMER_CONTROL, 8'h30);
    wr(`ADDR_IRQ_ENABLE, 8'h8D);
    chk_bit(t0_irq_req, 1'b1);
    ack(0);
    rdchk(`ADDR_TIMER_CONTROL, 8'h10);
    chk_bit(t0_irq_req, 1'b0);
    wr(`ADDR_EVENT_STATUS, 8'h01);
    chk_bit(irq, 1'b0);
    set_t0(8'h05, 8'h00, 8'h00);
    n = $urandom_range(12, 1);
    pp_u.pulse_count(0, n);
    repeat (6) @(posedge clk_sys);
    rdchk(`ADDR_T0_COUNT_LOW, 8'(n));
    wr(`ADDR_TIMER_MODE, 8'h0D);
    pp_u.set_ext(0, 1'b0);
    pp_u.pulse_count(0, 3);
    repeat (6) @(posedge clk_sys);
    rdchk(`ADDR_T0_COUNT_LOW, 8'(n));
    rdchk(`ADDR_TIMER_CONTROL, 8'h12);
    pp_u.set_ext(0, 1'b1);
    pp_u.pulse_count(0, 2);
    repeat (6) @(posedge clk_sys);
    rdchk(`ADDR_T0_COUNT_LOW, 8'(n + 2));
    rdchk(`ADDR_TIMER_CONTROL, 8'h10);
    wr(`ADDR_TIMER_CONTROL, 8'h05);
    for (int i = 0; i < 2; i++)
    begin
      pp_u.set_ext(i, 1'b0);
      pp_u.set_ext(i, 1'b1);
      rdchk(`ADDR_TIMER_CONTROL, 8'h05 | (8'h02 << (2 * i)));
      chk_bit((i == 0) ? ext0_irq_req : ext1_irq_req, 1'b1);
      chk_bit((i == 0) ? ext1_irq_req : ext0_irq_req, 1'b0);
      ack(2 + i);
      rdchk(`ADDR_TIMER_CONTROL, 8'h05);
    end
    close_out();
  end
endmodule
`default_nettype wire
